// >>> pkg/zdb_regs.svh
// named constants of the zero delay clock fanout control block
`ifndef ZDB_REGS_SVH
`define ZDB_REGS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define ZDB_HALF_W      4
`define ZDB_CNT_W       5
`define ZDB_FRZ_W       12
`define ZDB_CNT_RX_W    4
`define ZDB_MULT_W      6
`define ZDB_NUM_DIV     4

// ****************************************************************
// divider indices: bank a, bank b, bank c, loop return
// ****************************************************************
`define ZDB_DIV_A       0
`define ZDB_DIV_B       1
`define ZDB_DIV_C       2
`define ZDB_DIV_FB      3

// ****************************************************************
// half periods in post-halving ticks, per two-bit select
// ****************************************************************
`define ZDB_A_H0        4'h2
`define ZDB_A_H1        4'h3
`define ZDB_A_H2        4'h4
`define ZDB_A_H3        4'h6
`define ZDB_B_H0        4'h2
`define ZDB_B_H1        4'h3
`define ZDB_B_H2        4'h4
`define ZDB_B_H3        4'h5
`define ZDB_C_H0        4'h1
`define ZDB_C_H1        4'h2
`define ZDB_C_H2        4'h3
`define ZDB_C_H3        4'h4

// ****************************************************************
// loop return half periods per three-bit feedback select
// ****************************************************************
`define ZDB_F_H0        4'h2
`define ZDB_F_H1        4'h3
`define ZDB_F_H2        4'h4
`define ZDB_F_H3        4'h5
`define ZDB_F_H4        4'h4
`define ZDB_F_H5        4'h6
`define ZDB_F_H6        4'h8
`define ZDB_F_H7        4'ha

// ****************************************************************
// serial freeze frame and reset values
// ****************************************************************
`define ZDB_BIT_A0      0
`define ZDB_BIT_B0      4
`define ZDB_BIT_C1      8
`define ZDB_BIT_C2      9
`define ZDB_BIT_C3      10
`define ZDB_BIT_SYNC    11
`define ZDB_RX_LAST     4'hb
`define ZDB_RX_ONE      4'h1
`define ZDB_START_BIT   1'h0
`define ZDB_FRZ_RESET   12'hfff
`define ZDB_HALF_RESET  4'h2
`define ZDB_CNT_RESET   5'h03
`define ZDB_CNT_ONE     5'h01
`define ZDB_MULT_MAX    6'h28

`endif

// >>> pkg/zdb_pkg.sv
// types shared by the clock fanout control design files
package zdb_pkg;
`include "zdb_regs.svh"

   // serial freeze receiver states
   typedef enum logic [1:0] {
      ZDB_RX_IDLE  = 2'b01,
      ZDB_RX_SHIFT = 2'b10
   } zdb_rx_type;

   // state of one output divider
   typedef struct packed {
      logic [`ZDB_HALF_W-1:0] half;
      logic [`ZDB_CNT_W-1:0]  cnt;
      logic                   lvl;
   } zdb_div_state_type;

   // state of the top module
   typedef struct packed {
      logic                     ref_prev;
      logic                     sck_prev;
      logic                     halve;
      logic                     halve_ph;
      zdb_rx_type               rx_state;
      logic [`ZDB_CNT_RX_W-1:0] rx_cnt;
      logic [`ZDB_FRZ_W-1:0]    rx_sr;
      logic [`ZDB_FRZ_W-1:0]    freeze;
      logic [`ZDB_FRZ_W-1:0]    gate;
      logic [`ZDB_FRZ_W-1:0]    outv;
      logic                     c0;
      logic                     fb;
      logic                     xo;
      logic [`ZDB_MULT_W-1:0]   mult;
   } zdb_state_type;

endpackage

// >>> rtl/zdb_divider.sv
// glitch-free integer divider for one output bank or the loop return
`timescale 1ns/1ps
`include "zdb_regs.svh"
module zdb_divider
   import zdb_pkg::*;
(
   // clock and clear
   input  wire logic                   clk,
   input  wire logic                   clr_n,
   // rate
   input  wire logic                   tick,
   input  wire logic [`ZDB_HALF_W-1:0] half_sel,
   // state seen by the top
   output logic                        lvl,
   output logic                        wrap,
   output logic [`ZDB_CNT_W-1:0]       rem,
   output logic [`ZDB_HALF_W-1:0]      half
);

   // ****************************************************************
   // period counter
   // ****************************************************************
   zdb_div_state_type s_q;
   zdb_div_state_type s_d;
   logic [`ZDB_CNT_W-1:0] per;
   logic                  at_last;

   assign per     = {s_q.half, 1'b0};
   assign at_last = s_q.cnt == per - `ZDB_CNT_ONE;
   assign wrap    = tick && at_last;
   assign rem     = per - s_q.cnt;
   assign lvl     = s_q.lvl;
   assign half    = s_q.half;

   // new ratio only taken at a period boundary, so no runt or stretch
   always_comb
   begin
      s_d = s_q;
      if (!clr_n)
      begin
         s_d.half = `ZDB_HALF_RESET;
         s_d.cnt  = `ZDB_CNT_RESET;
         s_d.lvl  = 1'b0;
      end
      else if (tick)
      begin
         if (at_last)
         begin
            s_d.cnt  = '0;
            s_d.half = half_sel; // R15
         end
         else
         begin
            s_d.cnt = s_q.cnt + `ZDB_CNT_ONE;
         end
         s_d.lvl = s_d.cnt < {1'b0, s_d.half};
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      s_q <= s_d;
   end

   // ratio held steady between boundaries
   a_ratio_steady: assert property (@(posedge clk) disable iff (!clr_n) // R15
      !wrap |=> $stable(s_q.half))
      else $error("divider ratio changed mid period");

endmodule

// >>> rtl/zdb_fanout_ctrl.sv
// control logic of the multi-output zero delay clock fanout buffer
//
// Overview of operation
// R1: oscillator multiple from halving and feedback selects
// R2: feedback select sets loop return divide ratio
// R3: halving low divides oscillator by two
// R4: loop enable low: reference drives outputs directly; here reference rises clock the dividers instead
// R5: source choice high picks crystal reference
// R6: external choice picks reference clock zero/one
// R7: master clear low resets, disables all outputs
// R8: master clear high releases reset, enables outputs
// R9: late bank invert flips bank c outputs 2,3
// R10: sync pulse rises with coincident a/c edges
// R11: each bank select picks its own ratio
// R12: shift clock loads serial freeze register
// R13: freeze register gates outputs individually
// R14: twelve outputs in three banks of four
// R15: ratio changes make no runt or stretch
// R16: reference clocks switchable on the fly
// R17: bank ratio tables per halving and select
// R18: zero start bit then twelve bits, rising edge
// R19: bit map a0-3, b0-3, c1-3, sync
// R20: zero freezes low cleanly; c0, loop never
// R21: unconnected controls default high
`timescale 1ns/1ps
`include "zdb_regs.svh"
module zdb_fanout_ctrl
   import zdb_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       nrst,
   // reference selection
   input  wire logic       crystal_in,
   input  wire logic       ext_ref_clk_zero,
   input  wire logic       ext_ref_clk_one,
   input  wire logic       source_choice,
   input  wire logic       ext_ref_choice,
   input  wire logic       loop_enable,
   // ratio selection
   input  wire logic       osc_halving_select,
   input  wire logic [2:0] feedback_ratio_select,
   input  wire logic [1:0] bank_a_ratio_select,
   input  wire logic [1:0] bank_b_ratio_select,
   input  wire logic [1:0] bank_c_ratio_select,
   input  wire logic       late_bank_invert,
   input  wire logic       master_clear_out_enable,
   // serial freeze port
   input  wire logic       freeze_shift_clk,
   input  wire logic       freeze_shift_in,
   // clock outputs
   output logic [3:0]      bank_a_clk_out,
   output logic [3:0]      bank_b_clk_out,
   output logic [3:0]      bank_c_clk_out,
   output logic            loop_return_clk_out,
   output logic            sync_pulse_out,
   // crystal drive and status
   output logic            crystal_out,
   output logic [5:0]      osc_multiple
);

   // ****************************************************************
   // state and divider wiring
   // ****************************************************************
   zdb_state_type st_q;
   zdb_state_type st_d;

   logic                   clr_n;
   logic                   ref_sel;
   logic                   ref_rise;
   logic                   base_tick;
   logic                   tick;
   logic                   sck_rise;
   logic                   sync_raw;
   logic [`ZDB_FRZ_W-1:0]  raw;
   logic [`ZDB_HALF_W-1:0] half_sel [`ZDB_NUM_DIV];
   logic                   div_lvl  [`ZDB_NUM_DIV];
   logic                   div_wrap [`ZDB_NUM_DIV];
   logic [`ZDB_CNT_W-1:0]  div_rem  [`ZDB_NUM_DIV];
   logic [`ZDB_HALF_W-1:0] div_half [`ZDB_NUM_DIV];

   // master clear acts as a second synchronous reset
   assign clr_n = nrst && master_clear_out_enable; // R7 R8

   // ****************************************************************
   // reference path
   // ****************************************************************
   // plain mux: a switch may give one early edge, or lose the new source's rise if the old source was high
   assign ref_sel = source_choice ? crystal_in : // R5
                    (ext_ref_choice ? ext_ref_clk_one : // R6 R16
                     ext_ref_clk_zero);
   assign ref_rise  = ref_sel && !st_q.ref_prev;
   // clk stands in for the locked oscillator; bypass uses ref edges
   assign base_tick = loop_enable || ref_rise; // R4
   assign tick      = base_tick && (st_q.halve || st_q.halve_ph); // R3
   assign sck_rise  = freeze_shift_clk && !st_q.sck_prev; // R18

   // ****************************************************************
   // ratio decode
   // ****************************************************************
   always_comb
   begin
      unique case (bank_a_ratio_select) // R11 R17
         2'h0: half_sel[`ZDB_DIV_A] = `ZDB_A_H0;
         2'h1: half_sel[`ZDB_DIV_A] = `ZDB_A_H1;
         2'h2: half_sel[`ZDB_DIV_A] = `ZDB_A_H2;
         2'h3: half_sel[`ZDB_DIV_A] = `ZDB_A_H3;
      endcase
      unique case (bank_b_ratio_select) // R11 R17
         2'h0: half_sel[`ZDB_DIV_B] = `ZDB_B_H0;
         2'h1: half_sel[`ZDB_DIV_B] = `ZDB_B_H1;
         2'h2: half_sel[`ZDB_DIV_B] = `ZDB_B_H2;
         2'h3: half_sel[`ZDB_DIV_B] = `ZDB_B_H3;
      endcase
      unique case (bank_c_ratio_select) // R11 R17
         2'h0: half_sel[`ZDB_DIV_C] = `ZDB_C_H0;
         2'h1: half_sel[`ZDB_DIV_C] = `ZDB_C_H1;
         2'h2: half_sel[`ZDB_DIV_C] = `ZDB_C_H2;
         2'h3: half_sel[`ZDB_DIV_C] = `ZDB_C_H3;
      endcase
      // a and c take new ratios only together, so they stay in phase
      // and a coincident rise always exists for the sync pulse
      if (!(div_wrap[`ZDB_DIV_A] && div_wrap[`ZDB_DIV_C]))
      begin
         half_sel[`ZDB_DIV_A] = div_half[`ZDB_DIV_A]; // R10 R15
         half_sel[`ZDB_DIV_C] = div_half[`ZDB_DIV_C];
      end
      unique case (feedback_ratio_select) // R2
         3'h0: half_sel[`ZDB_DIV_FB] = `ZDB_F_H0;
         3'h1: half_sel[`ZDB_DIV_FB] = `ZDB_F_H1;
         3'h2: half_sel[`ZDB_DIV_FB] = `ZDB_F_H2;
         3'h3: half_sel[`ZDB_DIV_FB] = `ZDB_F_H3;
         3'h4: half_sel[`ZDB_DIV_FB] = `ZDB_F_H4;
         3'h5: half_sel[`ZDB_DIV_FB] = `ZDB_F_H5;
         3'h6: half_sel[`ZDB_DIV_FB] = `ZDB_F_H6;
         3'h7: half_sel[`ZDB_DIV_FB] = `ZDB_F_H7;
      endcase
   end

   // ****************************************************************
   // dividers: bank a, bank b, bank c, loop return
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < `ZDB_NUM_DIV; gi++)
      begin : g_div
         zdb_divider u_div (
            .clk      (clk),
            .clr_n    (clr_n),
            .tick     (tick),
            .half_sel (half_sel[gi]),
            .lvl      (div_lvl[gi]),
            .wrap     (div_wrap[gi]),
            .rem      (div_rem[gi]),
            .half     (div_half[gi])
         );
      end
   endgenerate

   // ****************************************************************
   // sync prediction and raw output levels
   // ****************************************************************
   // next a and c rises coincide exactly when their remaining ticks
   // match; that only happens in the faster clock's last period
   always_comb
   begin
      sync_raw = !(div_rem[`ZDB_DIV_A] == div_rem[`ZDB_DIV_C] && // R10
                   !(div_half[`ZDB_DIV_A] == div_half[`ZDB_DIV_C] &&
                     div_rem[`ZDB_DIV_A] >
                     {1'b0, div_half[`ZDB_DIV_A]}));
      raw = '0;
      raw[`ZDB_BIT_A0 +: 4] = {4{div_lvl[`ZDB_DIV_A]}}; // R14
      raw[`ZDB_BIT_B0 +: 4] = {4{div_lvl[`ZDB_DIV_B]}};
      raw[`ZDB_BIT_C1]      = div_lvl[`ZDB_DIV_C];
      raw[`ZDB_BIT_C2]      = div_lvl[`ZDB_DIV_C] ^ late_bank_invert; // R9
      raw[`ZDB_BIT_C3]      = div_lvl[`ZDB_DIV_C] ^ late_bank_invert; // R9
      raw[`ZDB_BIT_SYNC]    = sync_raw;
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      st_d          = st_q;
      st_d.ref_prev = ref_sel;
      st_d.sck_prev = freeze_shift_clk;
      st_d.xo       = !crystal_in;
      if (base_tick && !st_q.halve)
      begin
         st_d.halve_ph = !st_q.halve_ph; // R3
      end
      // halving only moves at an a/c coincidence, keeping ratios whole
      if (div_wrap[`ZDB_DIV_A] && div_wrap[`ZDB_DIV_C])
      begin
         st_d.halve = osc_halving_select; // R15
      end
      // multiple of the reference that the oscillator must run at
      st_d.mult = st_q.halve ? // R1
                  {1'b0, half_sel[`ZDB_DIV_FB], 1'b0} :
                  {half_sel[`ZDB_DIV_FB], 2'b00};
      // serial freeze receiver
      if (sck_rise)
      begin
         unique case (st_q.rx_state)
            ZDB_RX_IDLE:
            begin
               if (freeze_shift_in == `ZDB_START_BIT) // R18
               begin
                  st_d.rx_state = ZDB_RX_SHIFT;
                  st_d.rx_cnt   = '0;
               end
            end
            ZDB_RX_SHIFT:
            begin
               st_d.rx_sr[st_q.rx_cnt] = freeze_shift_in; // R12 R19
               if (st_q.rx_cnt == `ZDB_RX_LAST)
               begin
                  st_d.freeze   = st_d.rx_sr; // R12
                  st_d.rx_state = ZDB_RX_IDLE;
               end
               else
               begin
                  st_d.rx_cnt = st_q.rx_cnt + `ZDB_RX_ONE;
               end
            end
         endcase
      end
      // gates only move while their output is low: no partial pulse
      for (int i = 0; i < `ZDB_FRZ_W; i++)
      begin
         st_d.gate[i] = raw[i] ? st_q.gate[i] : st_q.freeze[i]; // R20
         st_d.outv[i] = raw[i] && st_q.gate[i]; // R13
      end
      st_d.c0 = div_lvl[`ZDB_DIV_C]; // R20
      st_d.fb = div_lvl[`ZDB_DIV_FB]; // R2 R20
      if (!clr_n)
      begin
         st_d          = '0; // R7
         st_d.halve    = 1'b1; // R21
         st_d.halve_ph = 1'b0; // first halved period not cut short
         st_d.rx_state = ZDB_RX_IDLE;
         st_d.freeze   = `ZDB_FRZ_RESET; // R21
         st_d.gate     = `ZDB_FRZ_RESET;
         st_d.ref_prev = ref_sel;
         st_d.sck_prev = freeze_shift_clk;
      end
   end

   // state register
   always_ff @(posedge clk)
   begin
      st_q <= st_d;
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign bank_a_clk_out      = st_q.outv[`ZDB_BIT_A0 +: 4];
   assign bank_b_clk_out      = st_q.outv[`ZDB_BIT_B0 +: 4];
   assign bank_c_clk_out      = {st_q.outv[`ZDB_BIT_C3:`ZDB_BIT_C1],
                                 st_q.c0};
   assign loop_return_clk_out = st_q.fb;
   assign sync_pulse_out      = st_q.outv[`ZDB_BIT_SYNC];
   assign crystal_out         = st_q.xo;
   assign osc_multiple        = st_q.mult;

   // ****************************************************************
   // checks
   // ****************************************************************
   a_clear_outputs_low: assert property (@(posedge clk) disable iff (!nrst)
      !master_clear_out_enable |=> // R7
      bank_a_clk_out == 4'h0 && bank_c_clk_out == 4'h0 &&
      !loop_return_clk_out && !sync_pulse_out)
      else $error("outputs active during master clear");

   a_c0_never_frozen: assert property (@(posedge clk) disable iff (!clr_n)
      $past(clr_n) |-> bank_c_clk_out[0] == $past(div_lvl[`ZDB_DIV_C])) // R20
      else $error("bank c output zero not following its divider");

   a_invert_late_pair: assert property (@(posedge clk) disable iff (!clr_n)
      $past(clr_n) && $past(st_q.gate[`ZDB_BIT_C2]) |-> // R9
      bank_c_clk_out[2] ==
      ($past(div_lvl[`ZDB_DIV_C]) ^ $past(late_bank_invert)))
      else $error("bank c output two inversion wrong");

   a_frozen_stays_low: assert property (@(posedge clk) disable iff (!clr_n)
      !st_q.gate[`ZDB_BIT_A0] && !st_q.freeze[`ZDB_BIT_A0] |=> // R20
      !bank_a_clk_out[0] [*2])
      else $error("frozen output pulsed");

   a_sync_with_edges: assert property (@(posedge clk) disable iff (!clr_n)
      $rose(sync_pulse_out) && $past(st_q.gate[`ZDB_BIT_A0]) &&
      $past(st_q.gate[`ZDB_BIT_C1]) |-> // R10
      $rose(bank_a_clk_out[0]) && $rose(bank_c_clk_out[1]))
      else $error("sync rise not at coincident a and c edges");

   a_multiple_top: assert property (@(posedge clk) disable iff (!clr_n)
      $past(clr_n) && $past(feedback_ratio_select) == 3'h7 &&
      !$past(st_q.halve) |-> osc_multiple == `ZDB_MULT_MAX) // R1
      else $error("oscillator multiple wrong at top setting");

   a_serial_commit: assert property (@(posedge clk) disable iff (!clr_n)
      st_q.rx_state == ZDB_RX_SHIFT && st_q.rx_cnt == `ZDB_RX_LAST &&
      sck_rise |=> // R18 R12
      st_q.freeze == {$past(freeze_shift_in),
                      $past(st_q.rx_sr[`ZDB_BIT_SYNC-1:0])} &&
      st_q.rx_state == ZDB_RX_IDLE)
      else $error("freeze frame not committed after twelve bits");

   a_bypass_waits_ref: assert property (@(posedge clk) disable iff (!clr_n)
      !loop_enable && !ref_rise |=> $stable(g_div[0].u_div.s_q.cnt)) // R4
      else $error("bank a advanced without a reference edge in bypass");

endmodule

// >>> verification/zdb_ctrl_model.sv
// board controller model that loads the serial freeze register
`timescale 1ns/1ps
module zdb_ctrl_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        nrst,
   // frame request from the bench
   input  wire logic        go,
   input  wire logic [11:0] bits,
   output logic             busy,
   // serial freeze port
   output logic             sck,
   output logic             sdo
);
   logic [1:0]  cnt_q;
   logic [3:0]  idx_q;
   logic [11:0] sh_q;

   // free running shift clock, two clk low then two clk high
   assign sck = cnt_q[1];

   // data moves only while the shift clock is low, so it is stable at
   // every rise; the data line floats high between frames (pull-up)
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         cnt_q <= 2'h0;
         idx_q <= 4'h0;
         sh_q  <= 12'h000;
         sdo   <= 1'b1;
         busy  <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 2'h1;
         if (go && !busy)
         begin
            busy  <= 1'b1;
            sh_q  <= bits;
            idx_q <= 4'h0;
         end
         else if (busy && cnt_q == 2'h3)
         begin
            if (idx_q == 4'hd)
            begin
               busy <= 1'b0;
               sdo  <= 1'b1;
            end
            else
            begin
               // start bit zero, then d0 first
               sdo   <= (idx_q == 4'h0) ? 1'b0 : sh_q[idx_q - 4'h1];
               idx_q <= idx_q + 4'h1;
            end
         end
      end
   end
endmodule

// >>> verification/zdb_fanout_ctrl_test.sv
// self-checking bench of the clock fanout control block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH %0t got %0h want %0h", $time, a, e); end end
module zdb_fanout_ctrl_test;
   import zdb_pkg::*;
   // ****************************************************************
   // signals and helpers
   // ****************************************************************
   localparam int PA [4] = '{4, 6, 8, 12};
   localparam int PB [4] = '{4, 6, 8, 10};
   localparam int PC [4] = '{2, 4, 6, 8};
   localparam int PF [8] = '{4, 6, 8, 10, 8, 12, 16, 20};
   logic        clk = 1'b0, nrst = 1'b0, mc = 1'b1;
   logic        xi = 1'b0, e0 = 1'b0, e1 = 1'b0, r2 = 1'b0;
   logic        src = 1'b1, ech = 1'b0, len = 1'b1, halv = 1'b1;
   logic        inv = 1'b0, go = 1'b0, busy, sck, sdo, syn, lro;
   logic        xo, xp;
   logic [2:0]  fbs = 3'h0;
   logic [1:0]  sa = 2'h0, sb = 2'h0, sc = 2'h0, r3 = 2'h0;
   logic [3:0]  qa, qb, qc;
   logic [5:0]  mult;
   logic [11:0] fbits = 12'h000;
   logic [15:0] rnd = 16'h90a1;
   logic [13:0] seen;
   logic        chk_sync = 1'b0, chk_inv = 1'b0, sp, ap, cp, ok;
   int          err_total = 0, n_checks = 0, cyc = 0, p, h, s, n;
   wire  [13:0] outs = {syn, lro, qc, qb, qa};

   zdb_fanout_ctrl zdb_fanout_ctrl_inst (.clk(clk), .nrst(nrst),
      .crystal_in(xi), .ext_ref_clk_zero(e0), .ext_ref_clk_one(e1),
      .source_choice(src), .ext_ref_choice(ech), .loop_enable(len),
      .osc_halving_select(halv), .feedback_ratio_select(fbs),
      .bank_a_ratio_select(sa), .bank_b_ratio_select(sb),
      .bank_c_ratio_select(sc), .late_bank_invert(inv),
      .master_clear_out_enable(mc), .freeze_shift_clk(sck),
      .freeze_shift_in(sdo), .bank_a_clk_out(qa), .bank_b_clk_out(qb),
      .bank_c_clk_out(qc), .loop_return_clk_out(lro),
      .sync_pulse_out(syn), .crystal_out(xo), .osc_multiple(mult));
   zdb_ctrl_model zdb_ctrl_model_inst (.clk(clk), .nrst(nrst), .go(go),
      .bits(fbits), .busy(busy), .sck(sck), .sdo(sdo));

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // period in clk of bank k (3 is loop return) for select s
   function automatic int exp_per(input int k, input int s, input int h);
      int v;
      case (k)
         0: v = PA[s];
         1: v = PB[s];
         2: v = PC[s];
         default: v = PF[s];
      endcase
      exp_per = (h != 0) ? v : 2 * v;
   endfunction
   task automatic wait_rise(input int i, output int c);
      logic pv, r;
      pv = outs[i];
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
         r = outs[i] & ~pv;
         pv = outs[i];
      end
      while (r !== 1'b1 && c < 200);
   endtask
   task automatic measure(input int i, output int c);
      int d;
      wait_rise(i, d);
      wait_rise(i, c);
   endtask
   task automatic watch(input int c, output logic [13:0] v);
      v = 14'h0000;
      repeat (c)
      begin
         @(posedge clk);
         v = v | outs;
      end
   endtask
   // one frame through the controller model, bounded wait
   task automatic send(input logic [11:0] b);
      int c;
      @(posedge clk);
      go <= 1'b1;
      fbits <= b;
      @(posedge clk);
      go <= 1'b0;
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (busy !== 1'b0 && c < 100);
   endtask
   task test_done;
      if (err_total == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ****************************************************************
   // clock, references, monitors
   // ****************************************************************
   initial
   begin
      forever #20 clk = ~clk;
   end
   // crystal rises every 2 clk, ext zero every 4, ext one every 6
   always @(posedge clk)
   begin
      xi <= ~xi;
      r2 <= ~r2;
      if (r2)
         e0 <= ~e0;
      r3 <= (r3 == 2'h2) ? 2'h0 : r3 + 2'h1;
      if (r3 == 2'h2)
         e1 <= ~e1;
      cyc++;
      if (cyc == 60000)
      begin
         err_total++;
         test_done;
      end
   end
   // sync must rise with a and c rising together
   always @(posedge clk)
   begin
      if (chk_sync && syn && !sp)
         `CHK({qa[0] & ~ap, qc[0] & ~cp}, 2'b11)
      if (chk_inv)
      begin
         `CHK(qc[2], qc[1] ^ inv)
         `CHK(xo, ~xp)
      end
      sp = syn;
      ap = qa[0];
      cp = qc[0];
      xp = xi;
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial
   begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      // every feedback and bank select under both halving settings
      for (h = 0; h < 2; h++)
         for (s = 0; s < 8; s++)
         begin
            halv <= h[0];
            fbs <= s[2:0];
            sa <= s[1:0];
            sb <= s[1:0] + 2'h1;
            sc <= s[1:0] + 2'h2;
            repeat (120) @(posedge clk);
            `CHK(mult, 6'(exp_per(3, s, h)))
            measure(0, p);
            `CHK(p, exp_per(0, s % 4, h))
            measure(4, p);
            `CHK(p, exp_per(1, (s + 1) % 4, h))
            measure(8, p);
            `CHK(p, exp_per(2, (s + 2) % 4, h))
            measure(12, p);
            `CHK(p, exp_per(3, s, h))
         end
      // bypass: reference rises become ticks, sources switched live
      len <= 1'b0;
      sa <= 2'h0;
      for (s = 0; s < 3; s++)
      begin
         src <= (s == 0);
         ech <= (s == 2);
         repeat (80) @(posedge clk);
         measure(0, p);
         `CHK(p, 4 * (2 * s + 2))
      end
      len <= 1'b1;
      // random ratio and halving changes: no runt or stretched period
      chk_sync <= 1'b1;
      repeat (12)
      begin
         rnd = lfsr(rnd);
         halv <= rnd[8];
         sa <= rnd[1:0];
         sc <= rnd[3:2];
         repeat (rnd[7:4]) @(posedge clk);
         repeat (2)
         begin
            measure(0, p);
            ok = p inside {4, 6, 8, 12, 16, 24};
            `CHK(ok, 1'b1)
         end
      end
      chk_sync <= 1'b0;
      halv <= 1'b1;
      // inversion on, then off
      for (s = 1; s >= 0; s--)
      begin
         inv <= s[0];
         repeat (20) @(posedge clk);
         chk_inv <= 1'b1;
         repeat (30) @(posedge clk);
         chk_inv <= 1'b0;
      end
      // random freeze frame, then all frozen: c0 and loop keep running
      sa <= 2'h3;
      sc <= 2'h3;
      for (s = 0; s < 2; s++)
      begin
         rnd = lfsr(rnd);
         send((s == 0) ? rnd[11:0] : 12'h000);
         repeat (60) @(posedge clk);
         watch(60, seen);
         `CHK(seen, {fbits[11], 1'b1, fbits[10:8], 1'b1, fbits[7:0]})
      end
      // master clear holds all low, release restores enabled outputs
      mc <= 1'b0;
      repeat (3) @(posedge clk);
      watch(10, seen);
      `CHK(seen, 14'h0000)
      `CHK(mult, 6'h00)
      mc <= 1'b1;
      repeat (60) @(posedge clk);
      watch(60, seen);
      `CHK(seen, 14'h3fff)
      test_done;
   end
endmodule
